// ---- src/ifbe_pkg.sv ----
// How it works
// - Bad return frame format gives vector 14
// - Format error saves the detecting instruction address
// - Three active-low lines encode level 0 to 7
// - Level valid after two constant clock periods
// - Pending when valid level exceeds the mask
// - Level seven is edge triggered, never masked
// - Lowering the mask re-arms level comparison
// - Interrupt entry copies status, supervisor, no trace, mask
// - Pending output asserted low while pending
// - Acknowledge cycle drives level on modifier
// - Autovector request gives vector 24 plus level
// - Error-terminated acknowledge gives spurious vector 24
// - Push offset, counter and status copy
// - Master bit set on an interrupt builds throwaway frame
// - Throwaway status has supervisor forced set
// - Counter loaded from vector, then resume
// - Breakpoint opcodes run acknowledge cycle, modifier zero
// - Either termination leads to illegal instruction
// - Illegal instruction uses vector 4, no trace
// - Pending interrupt chains right after any entry
package ifbe_pkg;

    localparam logic [7:0] VEC_ILLEGAL = 8'h04;
    localparam logic [7:0] VEC_FORMAT = 8'h0e;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [3:0] FMT_NORMAL = 4'h0;
    localparam logic [3:0] FMT_THROW = 4'h1;
    localparam logic [15:0] BKPT_OPCODE = 16'h4848;
    localparam logic [15:0] BKPT_MASK = 16'hfff8;
    localparam logic [2:0] TM_BKPT = 3'h0;
    localparam logic [2:0] LEVEL_NMI = 3'h7;
    localparam int SR_T1 = 15;
    localparam int SR_T0 = 14;
    localparam int SR_S = 13;
    localparam int SR_M = 12;
    localparam int SR_MASK_LO = 8;
    localparam logic [15:0] SR_RESET = 16'h2700;
    localparam logic [4:0] REG_SR = 5'h00;
    localparam logic [4:0] REG_VBASE = 5'h04;
    localparam logic [4:0] REG_ISP = 5'h08;
    localparam logic [4:0] REG_MSP = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [31:0] SP_WORD_OFS = 32'h2;
    localparam logic [31:0] FMT_WORD_OFS = 32'h6;
    localparam logic [31:0] FRAME_BYTES = 32'h8;

    typedef enum logic [4:0] {
        IFBE_IDLE = 5'b00001,
        IFBE_IACK = 5'b00010,
        IFBE_BKPT = 5'b00100,
        IFBE_PUSH = 5'b01000,
        IFBE_VFETCH = 5'b10000
    } ifbe_st_t;

    typedef struct packed {
        logic boundary;
        logic opcode_valid;
        logic [15:0] opcode;
        logic rte_check;
        logic [3:0] rte_format;
        logic [31:0] insn_pc;
        logic [31:0] next_pc;
    } ifbe_core_t;

    typedef struct packed {
        logic active;
        logic tt_ack;
        logic [2:0] tm;
    } ifbe_cycle_t;

    typedef struct packed {
        logic we;
        logic long_sz;
        logic [31:0] addr;
        logic [31:0] data;
    } ifbe_stack_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic autovector_req_n;
        logic [7:0] data;
    } ifbe_pins_t;

endpackage

// ---- src/ifbe_exception_unit.sv ----
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module ifbe_exception_unit (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Interrupt pins
    input wire logic [2:0] irq_level_n_in,
    output logic irq_pending_out_n,
    // Acknowledge bus cycle pins
    input wire logic xfer_ack_n_in,
    input wire logic xfer_err_ack_n_in,
    input wire logic autovector_req_n_in,
    input wire logic [7:0] iack_data_in,
    output ifbe_pkg::ifbe_cycle_t ack_cycle_out,
    // Core events
    input wire ifbe_pkg::ifbe_core_t core_in,
    // Stack writes
    output ifbe_pkg::ifbe_stack_t stack_out,
    input wire logic stack_ack_in,
    // Vector fetch
    output logic vec_rd_out,
    output logic [31:0] vec_addr_out,
    input wire logic [31:0] vec_data_in,
    input wire logic vec_ack_in,
    // Handler start
    output logic [31:0] handler_pc_out,
    output logic handler_go_out
);
    import ifbe_pkg::*;

    typedef struct packed {
        ifbe_st_t st;
        logic [15:0] sr;
        logic [31:0] vbase;
        logic [31:0] isp;
        logic [31:0] msp;
        logic [2:0] lvl_s1;
        logic [2:0] lvl_s2;
        logic [2:0] lvl_s3;
        logic [2:0] lvl_last;
        logic [2:0] lvl_valid;
        logic [2:0] lvl_prev;
        ifbe_pins_t pin_s1;
        ifbe_pins_t pin_s2;
        ifbe_pins_t pin_s3;
        logic nmi;
        logic pend;
        logic [7:0] vec;
        logic [2:0] lvl_srv;
        logic [15:0] sr_copy;
        logic [31:0] pc_save;
        logic throw;
        logic second;
        logic [1:0] idx;
        logic [31:0] base;
        logic [31:0] tbase;
        ifbe_cycle_t cyc;
        ifbe_stack_t stk;
        logic vrd;
        logic [31:0] vaddr;
        logic [31:0] hpc;
        logic go;
        logic bus_ack;
        logic [31:0] rdata;
    } ifbe_state_t;

    ifbe_state_t r_ff;
    ifbe_state_t nxt_r;
    logic ack_seen;
    logic err_seen;
    logic fmt_ok;
    logic is_bkpt;

    function automatic logic [31:0] f_be(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Common entry: status copy, supervisor on, tracing off
    function automatic ifbe_state_t f_enter(input ifbe_state_t s, input logic [31:0] pc);
        ifbe_state_t o;
        o = s;
        o.sr_copy = s.sr;
        o.sr[SR_S] = 1'b1;
        o.sr[SR_T1] = 1'b0;
        o.sr[SR_T0] = 1'b0;
        o.pc_save = pc;
        return o;
    endfunction

    function automatic ifbe_state_t f_irq(input ifbe_state_t s, input logic [31:0] pc);
        ifbe_state_t o;
        logic [2:0] lvl;
        lvl = s.nmi ? LEVEL_NMI : s.lvl_valid;
        o = f_enter(s, pc);
        o.lvl_srv = lvl;
        o.sr[SR_MASK_LO +: 3] = lvl;
        if (lvl == LEVEL_NMI) begin
            o.nmi = 1'b0;
        end
        o.st = IFBE_IACK;
        o.cyc.active = 1'b1;
        o.cyc.tt_ack = 1'b1;
        o.cyc.tm = lvl;
        return o;
    endfunction

    // pick stacks, clear master bit on interrupts, reserve frames
    function automatic ifbe_state_t f_push(input ifbe_state_t s, input logic [7:0] vec);
        ifbe_state_t o;
        logic irq;
        o = s;
        // Only interrupts build the throwaway frame and leave master state
        irq = (s.st == IFBE_IACK);
        o.vec = vec;
        o.idx = 2'd0;
        o.second = 1'b0;
        o.throw = irq && s.sr_copy[SR_M];
        o.tbase = s.isp - FRAME_BYTES;
        if (s.sr_copy[SR_M]) begin
            o.base = s.msp - FRAME_BYTES;
            o.msp = s.msp - FRAME_BYTES;
        end else begin
            o.base = s.isp - FRAME_BYTES;
        end
        if (irq || !s.sr_copy[SR_M]) begin
            o.isp = s.isp - FRAME_BYTES;
        end
        if (irq) begin
            o.sr[SR_M] = 1'b0;
        end
        o.st = IFBE_PUSH;
        return o;
    endfunction

    // Terminations seen only once two synchroniser stages agree
    assign ack_seen = r_ff.pin_s2.ack & r_ff.pin_s3.ack;
    assign err_seen = r_ff.pin_s2.err & r_ff.pin_s3.err;
    assign fmt_ok = core_in.rte_format inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    assign is_bkpt = (core_in.opcode & BKPT_MASK) == BKPT_OPCODE;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.go = 1'b0;
        // active-low lines, lowest line is bit 0
        nxt_r.lvl_s1 = ~irq_level_n_in;
        nxt_r.lvl_s2 = r_ff.lvl_s1;
        nxt_r.lvl_s3 = r_ff.lvl_s2;
        nxt_r.pin_s1 = '{ack: ~xfer_ack_n_in, err: ~xfer_err_ack_n_in,
                         autovector_req_n: ~autovector_req_n_in, data: iack_data_in};
        nxt_r.pin_s2 = r_ff.pin_s1;
        nxt_r.pin_s3 = r_ff.pin_s2;
        // accept only after two constant periods
        nxt_r.lvl_last = r_ff.lvl_s3;
        if (r_ff.lvl_s2 == r_ff.lvl_s3 && r_ff.lvl_s3 == r_ff.lvl_last) begin
            nxt_r.lvl_valid = r_ff.lvl_s3;
        end
        nxt_r.lvl_prev = r_ff.lvl_valid;

        // Register access, one wait state per request
        nxt_r.bus_ack = (avs_read_in | avs_write_in) & ~r_ff.bus_ack;
        if (avs_read_in && !r_ff.bus_ack) begin
            unique case (avs_address_in)
                REG_SR: nxt_r.rdata = {16'h0, r_ff.sr};
                REG_VBASE: nxt_r.rdata = r_ff.vbase;
                REG_ISP: nxt_r.rdata = r_ff.isp;
                REG_MSP: nxt_r.rdata = r_ff.msp;
                REG_STATUS: nxt_r.rdata = {11'h0, r_ff.st, r_ff.vec, 1'b0, r_ff.lvl_valid,
                                           3'h0, r_ff.pend};
                default: nxt_r.rdata = 32'h0;
            endcase
        end
        if (avs_write_in && r_ff.bus_ack) begin
            unique case (avs_address_in)
                REG_SR: nxt_r.sr = 16'(f_be({16'h0, r_ff.sr}, avs_writedata_in,
                                            avs_byteenable_in));
                REG_VBASE: nxt_r.vbase = f_be(r_ff.vbase, avs_writedata_in, avs_byteenable_in);
                REG_ISP: nxt_r.isp = f_be(r_ff.isp, avs_writedata_in, avs_byteenable_in);
                REG_MSP: nxt_r.msp = f_be(r_ff.msp, avs_writedata_in, avs_byteenable_in);
                default: nxt_r.vbase = r_ff.vbase;
            endcase
        end

        unique case (r_ff.st)
            IFBE_IDLE: begin
                if (core_in.rte_check && !fmt_ok) begin
                    // saved counter is the return op itself
                    nxt_r = f_push(f_enter(nxt_r, core_in.insn_pc), VEC_FORMAT);
                end else if (core_in.opcode_valid && is_bkpt) begin
                    nxt_r.st = IFBE_BKPT;
                    nxt_r.pc_save = core_in.insn_pc;
                    nxt_r.cyc = '{active: 1'b1, tt_ack: 1'b1, tm: TM_BKPT};
                end else if (core_in.boundary && r_ff.pend) begin
                    nxt_r = f_irq(nxt_r, core_in.next_pc);
                end
            end
            IFBE_IACK: begin
                // level held on modifier until termination
                if (err_seen) begin
                    nxt_r.cyc = '0;
                    nxt_r = f_push(nxt_r, VEC_SPURIOUS);
                end else if (ack_seen) begin
                    nxt_r.cyc = '0;
                    if (r_ff.pin_s3.autovector_req_n) begin
                        nxt_r = f_push(nxt_r, VEC_SPURIOUS + {5'h0, r_ff.lvl_srv});
                    end else begin
                        nxt_r = f_push(nxt_r, r_ff.pin_s3.data);
                    end
                end
            end
            IFBE_BKPT: begin
                if (ack_seen || err_seen) begin
                    nxt_r.cyc = '0;
                    nxt_r = f_push(f_enter(nxt_r, r_ff.pc_save), VEC_ILLEGAL);
                end
            end
            IFBE_PUSH: begin
                if (!r_ff.stk.we) begin
                    nxt_r.stk.we = 1'b1;
                    nxt_r.stk.long_sz = (r_ff.idx == 2'd1);
                    unique case (r_ff.idx)
                        2'd0: begin
                            nxt_r.stk.addr = r_ff.second ? r_ff.tbase : r_ff.base;
                            nxt_r.stk.data = {16'h0, r_ff.sr_copy | (16'(r_ff.second) << SR_S)};
                        end
                        2'd1: begin
                            nxt_r.stk.addr = (r_ff.second ? r_ff.tbase : r_ff.base) + SP_WORD_OFS;
                            nxt_r.stk.data = r_ff.pc_save;
                        end
                        default: begin
                            nxt_r.stk.addr = (r_ff.second ? r_ff.tbase : r_ff.base)
                                             + FMT_WORD_OFS;
                            nxt_r.stk.data = {16'h0, r_ff.second ? FMT_THROW : FMT_NORMAL,
                                              2'b00, r_ff.vec, 2'b00};
                        end
                    endcase
                end else if (stack_ack_in) begin
                    nxt_r.stk.we = 1'b0;
                    if (r_ff.idx == 2'd2) begin
                        nxt_r.idx = 2'd0;
                        // second frame on the interrupt stack
                        if (r_ff.throw && !r_ff.second) begin
                            nxt_r.second = 1'b1;
                        end else begin
                            nxt_r.st = IFBE_VFETCH;
                            nxt_r.vrd = 1'b1;
                            nxt_r.vaddr = r_ff.vbase + {22'h0, r_ff.vec, 2'b00};
                        end
                    end else begin
                        nxt_r.idx = r_ff.idx + 2'd1;
                    end
                end
            end
            IFBE_VFETCH: begin
                if (vec_ack_in) begin
                    nxt_r.vrd = 1'b0;
                    nxt_r.hpc = vec_data_in;
                    if (r_ff.pend) begin
                        nxt_r = f_irq(nxt_r, vec_data_in);
                    end else begin
                        nxt_r.go = 1'b1;
                        nxt_r.st = IFBE_IDLE;
                    end
                end
            end
            default: nxt_r.st = IFBE_IDLE;
        endcase

        // edge to seven sets the latch, set beats clear
        if (r_ff.lvl_valid == LEVEL_NMI && r_ff.lvl_prev != LEVEL_NMI) begin
            nxt_r.nmi = 1'b1;
        end
        // level above mask; a lowered mask re-arms it
        nxt_r.pend = nxt_r.nmi | (nxt_r.lvl_valid > nxt_r.sr[SR_MASK_LO +: 3]);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r_ff <= '0;
            r_ff.st <= IFBE_IDLE;
            r_ff.sr <= SR_RESET;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign avs_readdata_out = r_ff.rdata;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~r_ff.bus_ack;
    assign irq_pending_out_n = ~r_ff.pend;
    assign ack_cycle_out = r_ff.cyc;
    assign stack_out = r_ff.stk;
    assign vec_rd_out = r_ff.vrd;
    assign vec_addr_out = r_ff.vaddr;
    assign handler_pc_out = r_ff.hpc;
    assign handler_go_out = r_ff.go;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_fmt_err;
        r_ff.st == IFBE_IDLE && core_in.rte_check && !fmt_ok;
    endsequence
    sequence s_iack_err;
        r_ff.st == IFBE_IACK && err_seen;
    endsequence
    sequence s_iack_auto;
        r_ff.st == IFBE_IACK && !err_seen && ack_seen && r_ff.pin_s3.autovector_req_n;
    endsequence

    a_format_vector: assert property (s_fmt_err |=> r_ff.vec == 8'h0e
        && r_ff.st == IFBE_PUSH && r_ff.pc_save == $past(core_in.insn_pc))
        else $error("format error entry wrong");
    a_level_debounce: assert property ($changed(r_ff.lvl_valid) |->
        $past(r_ff.lvl_s3, 2) == r_ff.lvl_valid && $past(r_ff.lvl_last) == r_ff.lvl_valid)
        else $error("level accepted before being stable");
    a_pend_mask: assert property ((r_ff.lvl_valid > r_ff.sr[10:8]) |->
        !irq_pending_out_n)
        else $error("pending not shown above mask");
    a_nmi_edge: assert property (
        r_ff.lvl_valid == 3'h7 && $past(r_ff.lvl_valid) != 3'h7
        |=> r_ff.nmi && !irq_pending_out_n)
        else $error("level seven edge missed");
    a_irq_entry: assert property (r_ff.st == IFBE_IDLE && core_in.boundary && r_ff.pend
        && !core_in.rte_check && !core_in.opcode_valid |=> r_ff.st == IFBE_IACK
        && r_ff.sr[13] && !r_ff.sr[15] && !r_ff.sr[14] && r_ff.sr[10:8] == r_ff.lvl_srv)
        else $error("interrupt entry status wrong");
    a_iack_modifier: assert property (r_ff.st == IFBE_IACK |-> ack_cycle_out.active
        && ack_cycle_out.tt_ack && ack_cycle_out.tm == r_ff.lvl_srv)
        else $error("acknowledge cycle level wrong");
    a_autovector_num: assert property (s_iack_auto |=>
        r_ff.vec == 8'h18 + {5'h0, r_ff.lvl_srv})
        else $error("autovector number wrong");
    a_spurious_num: assert property (s_iack_err |=>
        r_ff.vec == 8'h18 && !ack_cycle_out.active)
        else $error("spurious vector wrong");
    a_bkpt_cycle: assert property (r_ff.st == IFBE_IDLE
        && !(core_in.rte_check && !fmt_ok)
        && core_in.opcode_valid && is_bkpt |=> r_ff.st == IFBE_BKPT
        && ack_cycle_out.tm == 3'h0 && ack_cycle_out.active)
        else $error("breakpoint cycle wrong");
    a_throw_status: assert property (r_ff.st == IFBE_PUSH && r_ff.second
        && r_ff.idx == 2'd0 && !r_ff.stk.we
        |=> stack_out.we && stack_out.data[13] && stack_out.addr == r_ff.tbase)
        else $error("throwaway status lacks supervisor");
    a_vector_load: assert property (r_ff.st == IFBE_VFETCH && vec_ack_in && !r_ff.pend
        |=> handler_go_out && handler_pc_out == $past(vec_data_in) && r_ff.st == IFBE_IDLE)
        else $error("handler start wrong");

endmodule

// ---- tb/ifbe_far_model.sv ----
`timescale 1ns/100ps
module ifbe_far_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Bench control
    input wire logic load_in,
    input wire logic [2:0] level_in,
    input wire logic [1:0] mode_in,
    input wire logic [7:0] vec_num_in,
    // Unit side
    input wire ifbe_pkg::ifbe_cycle_t cycle_in,
    input wire ifbe_pkg::ifbe_stack_t stack_in,
    input wire logic vec_rd_in,
    input wire logic [31:0] vec_addr_in,
    output logic [2:0] irq_level_n_out,
    output logic xfer_ack_n_out,
    output logic xfer_err_ack_n_out,
    output logic autovector_req_n_out,
    output logic [7:0] iack_data_out,
    output logic stack_ack_out,
    output logic vec_ack_out,
    output logic [31:0] vec_data_out
);
    import ifbe_pkg::*;
    logic [2:0] level_ff;
    logic [1:0] wait_ff;
    assign irq_level_n_out = ~level_ff;
    // never programmed (zero) answers vector 15
    assign iack_data_out = !cycle_in.active ? ~vec_num_in
                           : (vec_num_in == 8'h00 ? 8'h0f : vec_num_in);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_ff <= 3'h0;
            wait_ff <= 2'h0;
            xfer_ack_n_out <= 1'b1;
            xfer_err_ack_n_out <= 1'b1;
            autovector_req_n_out <= 1'b1;
            stack_ack_out <= 1'b0;
            vec_ack_out <= 1'b0;
            vec_data_out <= 32'h0;
        end else begin
            if (load_in) begin
                level_ff <= level_in;
            end else if (cycle_in.active && cycle_in.tm == level_ff) begin
                level_ff <= 3'h0;
            end
            if (!cycle_in.active) begin
                wait_ff <= 2'h0;
                xfer_ack_n_out <= 1'b1;
                xfer_err_ack_n_out <= 1'b1;
                autovector_req_n_out <= 1'b1;
            end else if (wait_ff != 2'h2) begin
                wait_ff <= wait_ff + 2'h1;
            end else begin
                xfer_ack_n_out <= (mode_in == 2'h2);
                xfer_err_ack_n_out <= (mode_in != 2'h2);
                autovector_req_n_out <= (mode_in != 2'h1);
            end
            stack_ack_out <= stack_in.we && !stack_ack_out;
            vec_ack_out <= vec_rd_in && !vec_ack_out;
            // Stale data inverted so it never matches by luck
            vec_data_out <= (vec_rd_in && !vec_ack_out) ? vec_addr_in + 32'h100 : ~vec_data_out;
        end
    end
endmodule

// ---- tb/ifbe_exception_unit_bench.sv ----
`timescale 1ns/100ps
module ifbe_exception_unit_bench;
    import ifbe_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] adr = 5'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, vadr, vdat, hpc, q;
    logic wreq, pend_n, ack_n, err_n, autovector_req_n_n, stk_ack, vrd, vack, go, ld = 1'b0;
    logic [2:0] ipl_n;
    logic [2:0] lvl = 3'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] idat;
    logic [7:0] vnum = 8'h40;
    ifbe_cycle_t cyc;
    ifbe_core_t core = '0;
    ifbe_stack_t stk;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #10 clk_in = ~clk_in;
    ifbe_exception_unit uut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .irq_level_n_in(ipl_n), .irq_pending_out_n(pend_n), .xfer_ack_n_in(ack_n),
        .xfer_err_ack_n_in(err_n), .autovector_req_n_in(autovector_req_n_n), .iack_data_in(idat),
        .ack_cycle_out(cyc), .core_in(core), .stack_out(stk), .stack_ack_in(stk_ack),
        .vec_rd_out(vrd), .vec_addr_out(vadr), .vec_data_in(vdat), .vec_ack_in(vack),
        .handler_pc_out(hpc), .handler_go_out(go));
    ifbe_far_model far (.clk_in(clk_in), .rst_in(rst_in), .load_in(ld), .level_in(lvl),
        .mode_in(mode), .vec_num_in(vnum), .cycle_in(cyc), .stack_in(stk), .vec_rd_in(vrd),
        .vec_addr_in(vadr), .irq_level_n_out(ipl_n), .xfer_ack_n_out(ack_n),
        .xfer_err_ack_n_out(err_n), .autovector_req_n_out(autovector_req_n_n), .iack_data_out(idat),
        .stack_ack_out(stk_ack), .vec_ack_out(vack), .vec_data_out(vdat));
    task finish_test;
        $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_in);
        while (wreq) @(posedge clk_in);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task req(input logic [2:0] l, input logic [1:0] m);
        @(posedge clk_in);
        lvl <= l;
        mode <= m;
        ld <= 1'b1;
        @(posedge clk_in);
        ld <= 1'b0;
    endtask
    task pend(input logic exp);
        logic s;
        s = 1'b0;
        repeat (15) begin
            @(negedge clk_in);
            if (pend_n === 1'b0) s = 1'b1;
        end
        chk(s, exp);
    endtask
    // Strobe one core event, follow it to the handler start
    task entry(input ifbe_core_t c, input logic [3:0] etm, input logic [7:0] ev, input int ew,
               input logic [31:0] epc);
        logic [3:0] tm;
        logic [31:0] pcw;
        int nw;
        logic done;
        tm = 4'hf;
        pcw = 32'h0;
        nw = 0;
        done = 1'b0;
        @(posedge clk_in);
        core <= c;
        @(posedge clk_in);
        core <= '0;
        repeat (300) if (!done) begin
            @(negedge clk_in);
            if (cyc.active) tm = {1'b0, cyc.tm};
            if (stk.we && stk_ack) nw++;
            if (stk.we && stk_ack && nw % 3 == 0)
                chk(stk.data[15:0], {nw == 6 ? 4'h1 : 4'h0, 2'b00, ev, 2'b00});
            if (stk.we && stk_ack && nw == 4) chk(stk.data[13], 1'b1);
            if (stk.we && stk_ack && stk.long_sz) pcw = stk.data;
            if (go) done = 1'b1;
            if (go) chk(hpc, 32'h2100 + {ev, 2'b00});
        end
        chk(done, 1'b1);
        chk(tm, etm);
        chk(nw, ew);
        chk(pcw, epc);
    endtask
    task irq_run(input logic [31:0] sr, input logic [2:0] l, input logic [1:0] m,
                 input logic [7:0] ev, input int nw, input logic [7:0] srhi);
        ifbe_core_t c;
        c = '0;
        c.boundary = 1'b1;
        c.next_pc = 32'h1230 + 32'(l);
        bus(1'b1, REG_SR, sr);
        req(l, m);
        pend(1'b1);
        entry(c, {1'b0, l}, ev, nw, c.next_pc);
        bus(1'b0, REG_SR, 32'h0);
        chk(q[15:8], srhi);
    endtask
    task s_regs;
        bus(1'b0, REG_SR, 32'h0);
        chk(q, 32'h2700);
        bus(1'b0, 5'h14, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, REG_VBASE, 32'h2000);
        bus(1'b0, REG_VBASE, 32'h0);
        chk(q, 32'h2000);
    endtask
    task s_level;
        irq_run(32'ha000, 3'h3, 2'h0, 8'h40, 3, 8'h23);
    endtask
    task s_autovector_req_n;
        irq_run(32'h2000, 3'h5, 2'h1, 8'h1d, 3, 8'h25);
    endtask
    task s_uninit;
        @(posedge clk_in);
        vnum <= 8'h00;
        irq_run(32'h2000, 3'h1, 2'h0, 8'h0f, 3, 8'h21);
        vnum <= 8'h40;
    endtask
    task s_spur;
        irq_run(32'h2200, 3'h3, 2'h2, 8'h18, 3, 8'h23);
    endtask
    task s_nmi;
        irq_run(32'h2700, 3'h7, 2'h0, 8'h40, 3, 8'h27);
    endtask
    task s_throw;
        irq_run(32'h3000, 3'h2, 2'h0, 8'h40, 6, 8'h22);
    endtask
    // Masked level comes in once the mask drops
    task s_mask;
        ifbe_core_t c;
        c = '0;
        c.boundary = 1'b1;
        c.next_pc = 32'h4440;
        bus(1'b1, REG_SR, 32'h2400);
        req(3'h4, 2'h0);
        pend(1'b0);
        bus(1'b1, REG_SR, 32'h2300);
        pend(1'b1);
        entry(c, 4'h4, 8'h40, 3, c.next_pc);
    endtask
    task s_bkpt;
        ifbe_core_t c;
        for (int i = 0; i < 8; i++) begin
            c = '0;
            c.opcode_valid = 1'b1;
            c.opcode = 16'h4848 + 16'(i);
            c.insn_pc = 32'h500 + 32'(i);
            req(3'h0, i[0] ? 2'h2 : 2'h0);
            entry(c, 4'h0, 8'h04, 3, c.insn_pc);
        end
    endtask
    task s_fmt;
        ifbe_core_t c;
        c = '0;
        c.rte_check = 1'b1;
        c.rte_format = 4'h5;
        c.insn_pc = 32'h777;
        entry(c, 4'hf, 8'h0e, 3, 32'h777);
    endtask
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        s_regs;
        s_level;
        s_autovector_req_n;
        s_uninit;
        s_spur;
        s_mask;
        s_nmi;
        s_throw;
        s_bkpt;
        s_fmt;
        finish_test;
    end
endmodule
